// *** ccc_defines.svh ***
// Constants for the cascade control coordinator: field codes and timing.
// Assumes inclusion by bare name; definitions only.
`ifndef CCC_DEFINES_SVH
`define CCC_DEFINES_SVH

// ----------------------------------------------------------------
// Configuration codes
// ----------------------------------------------------------------
`define CCC_FUNC_MASTER 8'h02
`define CCC_SRC_INTERNAL 1'b0
`define CCC_SRC_CASCADE 1'b1
`define CCC_SEL_NONE 4'h0

// ----------------------------------------------------------------
// Sensor break behaviour codes
// ----------------------------------------------------------------
`define CCC_BRK_NEUTRAL 2'h0
`define CCC_BRK_UPSCALE 2'h1
`define CCC_BRK_DOWNSCALE 2'h2

// ----------------------------------------------------------------
// Timing: controller cycle in microseconds, clock period in ns
// ----------------------------------------------------------------
`define CCC_CYCLE_US 62500
`define CCC_CLK_NS 100
`define CCC_CYCLE_CLKS ((`CCC_CYCLE_US * 1000) / `CCC_CLK_NS)

// Percent scale of the correcting output and feedback
`define CCC_PCT_FULL 8'h64
`define CCC_PCT_ZERO 8'h00
`define CCC_PCT_HALF 8'h32

`endif

// *** ccc_pkg.sv ***
// Types shared by the cascade control coordinator modules.
// Assumes nothing from its surroundings.
`default_nettype none
package ccc_pkg;
    // Role of a channel in a cascade
    typedef enum logic [1:0] {
        CCC_ROLE_NONE = 2'b00,
        CCC_ROLE_MASTER = 2'b01,
        CCC_ROLE_SLAVE = 2'b10
    } ccc_role_t;

    // Master operating state
    typedef enum logic [1:0] {
        CCC_MS_AUTO = 2'b00,
        CCC_MS_MANUAL = 2'b01,
        CCC_MS_CASC_MAN = 2'b10
    } ccc_mstate_t;
endpackage
`default_nettype wire

// *** ccc_xchg_if.sv ***
// Per-cycle exchange between channel logic and the latch store.
// Assumes one clock shared by all users.
`timescale 1ns/1ps
`default_nettype none
interface ccc_xchg_if #(parameter int CH = 8);
    logic tick;
    logic [CH*8-1:0] next_y;
    logic [CH*8-1:0] next_fb;
    logic [CH-1:0] next_open;
    logic [CH*8-1:0] y;
    logic [CH*8-1:0] fb;
    logic [CH-1:0] open;
    modport core (output tick, next_y, next_fb, next_open,
                  input y, fb, open);
    modport store (input tick, next_y, next_fb, next_open,
                   output y, fb, open);
endinterface
`default_nettype wire

// *** ccc_xchg_store.sv ***
// Holds exchanged words for one controller cycle.
// Assumes tick is a one-clock pulse from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module ccc_xchg_store #(
    parameter int CH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Exchange
    ccc_xchg_if.store xc
);
    // ----------------------------------------------------------------
    // Latching once per cycle so partners see it the next cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            xc.y <= '0;
            xc.fb <= '0;
            xc.open <= '0;
        end else if (xc.tick) begin
            xc.y <= xc.next_y;
            xc.fb <= xc.next_fb;
            xc.open <= xc.next_open;
        end
    end
endmodule
`default_nettype wire

// *** ccc_cycle_timer.sv ***
// Controller cycle tick generator.
// Assumes the system clock runs at the rate the cycle count assumes.
`include "ccc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ccc_cycle_timer #(
    parameter int CYCLE_CLKS = `CCC_CYCLE_CLKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Tick out
    output logic tick
);
    logic [31:0] count;

    // Count up, pulse when wrapping
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count <= 32'h00000000;
            tick <= 1'b0;
        end else if (count == 32'(CYCLE_CLKS - 1)) begin
            count <= 32'h00000000;
            tick <= 1'b1;
        end else begin
            count <= count + 32'h00000001;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** ccc_top.sv ***
// Cascade coordinator for eight controller channels.
// Assumes channel status and PID outputs come from same-clock logic.
//
// Notes on behaviour
// - Each of eight channels may be master or slave.
// - Two-level cascades only, one master with seven slaves up to four.
// - Master when function code 02, source 0, selector 0.
// - Slave when source is 1; selector 1..8 names its master.
// - One master output may feed several slaves.
// - Master output is 0..100 percent, routed to slave set-points.
// - Open slave returns its normalised process value to its master.
// - Master auto/manual or second set-point change leaves slaves alone.
// - Master outputs off forces its output and slave set-points to zero.
// - Master sensor break drives output up, down or neutral.
// - Self-tuning master output values pass through to slaves.
// - Slave events set the cascade open flag.
// - Cascade open flag is internal, no external access.
// - Master samples slave status every controller cycle.
// - Open cascade forces master manual, tracking slave feedback.
// - Operator manual adjustment blocked while cascade open.
// - Closing returns master to automatic only if it was before.
// - Several open slaves: last written feedback wins.
// - Controller cycle is 62.5 ms.
`include "ccc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ccc_top #(
    parameter int CH = 8,
    parameter int CYCLE_CLKS = `CCC_CYCLE_CLKS
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Per-channel controller state
    input wire logic [CH*8-1:0] PID_Y,
    input wire logic [CH*8-1:0] PROC_PCT,
    input wire logic [CH-1:0] AUTO_MODE,
    input wire logic [CH-1:0] SECOND_SETPOINT,
    input wire logic [CH-1:0] OUTPUTS_OFF,
    input wire logic [CH-1:0] SENSOR_BREAK,
    input wire logic [CH-1:0] TUNING,
    input wire logic [CH-1:0] EXT_TO_INT,
    input wire logic [CH*8-1:0] OPER_MANUAL,
    // Per-channel outputs and the cycle tick
    output logic [CH*8-1:0] CORRECT_OUT,
    output logic [CH*8-1:0] EXT_SETPOINT,
    output logic [CH-1:0] MASTER_MANUAL,
    output logic [CH-1:0] ROLE_SLAVE,
    output logic [CH-1:0] ROLE_MASTER,
    output logic CYCLE_TICK
);
    // ----------------------------------------------------------------
    // Register map: per channel two words, at 0x00 + 4*ch and 0x20 + 4*ch
    // ----------------------------------------------------------------
    // Words sit four bytes apart so each channel's word is aligned;
    // unmapped reads answer zero and unmapped writes are dropped
    localparam logic [7:0] MAIN_BASE = 8'h00;
    localparam logic [7:0] ROUTE_BASE = 8'h20;
    localparam logic [7:0] STATUS_ADDR = 8'h40;

    // Configuration, master state and last-cycle exchange snapshots
    logic [7:0] controller_function_field [CH];
    logic [CH-1:0] setpoint_source_field;
    logic [3:0] external_setpoint_selector [CH];
    logic [1:0] break_mode [CH];
    ccc_pkg::ccc_mstate_t mstate [CH];
    logic [CH-1:0] was_auto;
    logic [CH*8-1:0] manual_val;
    logic [CH-1:0] prev_cause;
    logic [CH*8-1:0] prev_fb;
    logic tick;
    logic [CH*8-1:0] next_correct;
    logic [CH*8-1:0] next_fb_w;
    logic [CH-1:0] next_open_w;
    logic [CH-1:0] is_master;
    logic [CH-1:0] is_slave;

    ccc_xchg_if #(.CH(CH)) xc ();

    // Channel role decode; a slave selector outside 1..8 leaves the
    // channel unassigned, so a stray write cannot hook it onto a
    // master that does not exist
    function automatic ccc_pkg::ccc_role_t role_of(
        input logic [7:0] func, input logic src, input logic [3:0] sel);
        ccc_pkg::ccc_role_t r;
        r = ccc_pkg::CCC_ROLE_NONE;
        if (src == `CCC_SRC_CASCADE && sel != `CCC_SEL_NONE &&
            sel <= 4'h8) begin
            r = ccc_pkg::CCC_ROLE_SLAVE;
        end else if (func == `CCC_FUNC_MASTER &&
                     src == `CCC_SRC_INTERNAL &&
                     sel == `CCC_SEL_NONE) begin
            r = ccc_pkg::CCC_ROLE_MASTER;
        end
        return r;
    endfunction

    // Saturate a value to the percent scale; inputs may overshoot,
    // the exchanged words never do
    function automatic logic [7:0] clip_pct(input logic [7:0] v);
        return (v > `CCC_PCT_FULL) ? `CCC_PCT_FULL : v;
    endfunction

    // ----------------------------------------------------------------
    // Cycle timer and exchange store
    // ----------------------------------------------------------------
    // Every exchange moves on the tick only, so a master always reads
    // slave values one full controller cycle old; this keeps the loop
    // free of same-cycle paths between channels
    ccc_cycle_timer #(.CYCLE_CLKS(CYCLE_CLKS)) u_timer (
        .clk(CLK),
        .reset_n(RESET_N),
        .tick(tick)
    );

    ccc_xchg_store #(.CH(CH)) u_store (
        .clk(CLK),
        .reset_n(RESET_N),
        .xc(xc.store)
    );

    assign xc.tick = tick;
    assign xc.next_y = next_correct;
    assign xc.next_fb = next_fb_w;
    assign xc.next_open = next_open_w;

    // Role vectors; only eight channels, so a loop is enough
    always_comb begin
        for (int i = 0; i < CH; i++) begin
            is_master[i] = role_of(controller_function_field[i],
                setpoint_source_field[i], external_setpoint_selector[i])
                == ccc_pkg::CCC_ROLE_MASTER;
            is_slave[i] = role_of(controller_function_field[i],
                setpoint_source_field[i], external_setpoint_selector[i])
                == ccc_pkg::CCC_ROLE_SLAVE;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Software writes per channel; slave selecting a non-master is
    // accepted but never sees a set-point, which keeps two levels
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            for (int i = 0; i < CH; i++) begin
                controller_function_field[i] <= 8'h00;
                external_setpoint_selector[i] <= 4'h0;
                break_mode[i] <= `CCC_BRK_NEUTRAL;
            end
            setpoint_source_field <= '0;
        end else if (WR) begin
            for (int i = 0; i < CH; i++) begin
                if (ADDR == MAIN_BASE + 8'(i * 4)) begin
                    controller_function_field[i] <= WDATA[7:0];
                    setpoint_source_field[i] <= WDATA[8];
                end else if (ADDR == ROUTE_BASE + 8'(i * 4)) begin
                    external_setpoint_selector[i] <= WDATA[3:0];
                    break_mode[i] <= WDATA[5:4];
                end
            end
        end
    end

    // Read back; the open flags are deliberately absent
    // Status word: master roles in the low byte, slaves above them
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            RDATA <= 32'h00000000;
        end else if (RD) begin
            RDATA <= 32'h00000000;
            if (ADDR == STATUS_ADDR) begin
                RDATA <= {16'h0000, 8'(is_slave), 8'(is_master)};
            end else begin
                for (int i = 0; i < CH; i++) begin
                    if (ADDR == MAIN_BASE + 8'(i * 4)) begin
                        RDATA <= {23'h000000, setpoint_source_field[i],
                                  controller_function_field[i]};
                    end else if (ADDR == ROUTE_BASE + 8'(i * 4)) begin
                        RDATA <= {26'h0000000, break_mode[i],
                                  external_setpoint_selector[i]};
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Slave side: open flag and normalised feedback
    // ----------------------------------------------------------------
    // Any listed event opens the cascade; master-only changes do not.
    // Feedback is zero while closed, so a master never tracks a slave
    // that has not opened
    always_comb begin
        for (int i = 0; i < CH; i++) begin
            next_open_w[i] = is_slave[i] & (!AUTO_MODE[i] |
                SECOND_SETPOINT[i] | OUTPUTS_OFF[i] | SENSOR_BREAK[i] |
                EXT_TO_INT[i] | TUNING[i]);
            next_fb_w[i*8 +: 8] = next_open_w[i] ?
                clip_pct(PROC_PCT[i*8 +: 8]) : 8'h00;
        end
    end

    // Keep last cycle's open flags and feedback, so the master can tell
    // which slave just opened or wrote a new value; comparing against
    // the tracking value instead would let the highest channel always
    // win. The newest writer wins when several are open
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            prev_cause <= '0;
            prev_fb <= '0;
        end else if (tick) begin
            prev_cause <= xc.open;
            prev_fb <= xc.fb;
        end
    end

    // ----------------------------------------------------------------
    // Master side: state per master, sampled each controller cycle
    // ----------------------------------------------------------------
    // State moves on the tick only, so outputs stand between ticks;
    // was_auto keeps the mode held at opening for the bumpless return,
    // and operator values are ignored while the cascade is open
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            for (int m = 0; m < CH; m++) begin
                mstate[m] <= ccc_pkg::CCC_MS_AUTO;
            end
            was_auto <= '0;
            manual_val <= '0;
        end else if (tick) begin
            for (int m = 0; m < CH; m++) begin
                logic any_open;
                logic [7:0] track;
                any_open = 1'b0;
                track = manual_val[m*8 +: 8];
                for (int s = 0; s < CH; s++) begin
                    if (xc.open[s] &&
                        external_setpoint_selector[s] == 4'(m + 1)) begin
                        any_open = 1'b1;
                        // Latest newly opened or changed feedback wins
                        if (!prev_cause[s] ||
                            xc.fb[s*8 +: 8] != prev_fb[s*8 +: 8]) begin
                            track = xc.fb[s*8 +: 8];
                        end
                    end
                end
                case (mstate[m])
                    ccc_pkg::CCC_MS_CASC_MAN: begin
                        if (!any_open || !is_master[m]) begin
                            mstate[m] <= was_auto[m] ?
                                ccc_pkg::CCC_MS_AUTO :
                                ccc_pkg::CCC_MS_MANUAL;
                        end
                        manual_val[m*8 +: 8] <= track;
                    end
                    default: begin
                        if (any_open && is_master[m]) begin
                            mstate[m] <= ccc_pkg::CCC_MS_CASC_MAN;
                            was_auto[m] <= AUTO_MODE[m];
                            manual_val[m*8 +: 8] <= track;
                        end else begin
                            mstate[m] <= AUTO_MODE[m] ?
                                ccc_pkg::CCC_MS_AUTO :
                                ccc_pkg::CCC_MS_MANUAL;
                            manual_val[m*8 +: 8] <=
                                OPER_MANUAL[m*8 +: 8];
                        end
                    end
                endcase
            end
        end
    end

    // Master correcting output, priority: off, break, cascade manual;
    // tuning and auto/manual/second set-point just pass PID_Y through.
    // Off and break win even in cascade manual, so a switched-off or
    // broken master never forwards a stale tracking value
    always_comb begin
        for (int m = 0; m < CH; m++) begin
            if (OUTPUTS_OFF[m]) begin
                next_correct[m*8 +: 8] = `CCC_PCT_ZERO;
            end else if (SENSOR_BREAK[m]) begin
                case (break_mode[m])
                    `CCC_BRK_UPSCALE: next_correct[m*8 +: 8] = `CCC_PCT_FULL;
                    `CCC_BRK_DOWNSCALE: next_correct[m*8 +: 8] = `CCC_PCT_ZERO;
                    default: next_correct[m*8 +: 8] = `CCC_PCT_HALF;
                endcase
            end else if (mstate[m] == ccc_pkg::CCC_MS_CASC_MAN) begin
                next_correct[m*8 +: 8] = manual_val[m*8 +: 8];
            end else begin
                // Covers auto, manual, second set-point and tuning
                next_correct[m*8 +: 8] = clip_pct(PID_Y[m*8 +: 8]);
            end
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    // Everything leaves through flip-flops; a set-point reads zero on
    // any channel that is not a slave of a configured master
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            CORRECT_OUT <= '0;
            EXT_SETPOINT <= '0;
            MASTER_MANUAL <= '0;
            ROLE_SLAVE <= '0;
            ROLE_MASTER <= '0;
            CYCLE_TICK <= 1'b0;
        end else begin
            CORRECT_OUT <= xc.y;
            CYCLE_TICK <= tick;
            ROLE_SLAVE <= is_slave;
            ROLE_MASTER <= is_master;
            for (int s = 0; s < CH; s++) begin
                MASTER_MANUAL[s] <= mstate[s] == ccc_pkg::CCC_MS_CASC_MAN;
                EXT_SETPOINT[s*8 +: 8] <= 8'h00;
                // Several slaves may share one master
                for (int m = 0; m < CH; m++) begin
                    if (is_slave[s] && is_master[m] &&
                        external_setpoint_selector[s] == 4'(m + 1)) begin
                        EXT_SETPOINT[s*8 +: 8] <= xc.y[m*8 +: 8];
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** ccc_top_checker.sv ***
// Port checker for the cascade coordinator, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ccc_top_chk #(
    parameter int CH = 8,
    parameter int CYCLE_CLKS = 16
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    // Channel outputs
    input wire logic [CH*8-1:0] CORRECT_OUT,
    input wire logic [CH-1:0] MASTER_MANUAL,
    input wire logic [CH-1:0] ROLE_SLAVE,
    input wire logic [CH-1:0] ROLE_MASTER,
    input wire logic CYCLE_TICK
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // ------------------------------------------------
    // Helper logic
    // ------------------------------------------------
    // Clocks since the last tick; the first period is skipped, as the
    // timer phase after reset is not pinned down
    int unsigned gap;
    logic seen;
    always_ff @(posedge CLK) begin
        if (!RESET_N || CYCLE_TICK) begin
            gap <= 0;
        end else begin
            gap <= gap + 1;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            seen <= 1'b0;
        end else if (CYCLE_TICK) begin
            seen <= 1'b1;
        end
    end
    // Exchanged values only move shortly after a tick
    sequence tick_recent;
        $past(CYCLE_TICK, 1) || $past(CYCLE_TICK, 2) || $past(CYCLE_TICK, 3);
    endsequence

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    chk_tick_period: assert property (
        CYCLE_TICK && seen |-> gap == CYCLE_CLKS - 1)
        else $error("controller cycle length wrong");
    chk_tick_pulse: assert property (CYCLE_TICK |=> !CYCLE_TICK)
        else $error("tick longer than one clock");
    chk_out_cycle: assert property (
        $changed(CORRECT_OUT) |-> tick_recent)
        else $error("correcting output moved between cycles");
    chk_mman_cycle: assert property (
        $changed(MASTER_MANUAL) |-> tick_recent)
        else $error("cascade manual moved between cycles");
    chk_role_excl: assert property (
        (ROLE_MASTER & ROLE_SLAVE) == '0)
        else $error("channel is master and slave at once");
    chk_mman_role: assert property (
        (MASTER_MANUAL & ~ROLE_MASTER) == '0)
        else $error("cascade manual on a non-master");
    chk_unmapped_rd: assert property (
        RD && ADDR == 8'h80 |=> RDATA == '0)
        else $error("unmapped read not zero");
    for (genvar i = 0; i < CH; i++) begin : g_ch
        chk_out_range: assert property (
            CORRECT_OUT[i*8 +: 8] <= 8'h64)
            else $error("correcting output above full scale");
    end
endmodule
bind ccc_top ccc_top_chk #(.CH(CH), .CYCLE_CLKS(CYCLE_CLKS)) ccc_top_chk_i (
    .CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .RD(RD), .RDATA(RDATA),
    .CORRECT_OUT(CORRECT_OUT), .MASTER_MANUAL(MASTER_MANUAL),
    .ROLE_SLAVE(ROLE_SLAVE), .ROLE_MASTER(ROLE_MASTER),
    .CYCLE_TICK(CYCLE_TICK));
`default_nettype wire

// *** ccc_chan_model.sv ***
// Model of the eight controller channels around the coordinator.
// Assumes the bench changes commands just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ccc_chan_model (
    // Clock and pace
    input wire logic clk,
    input wire logic slow,
    // Commanded state: output, process, manual, six status bytes
    input wire logic [239:0] cmd,
    // State seen by the coordinator
    output logic [239:0] chan
);
    logic [239:0] stage;
    initial chan = '0;
    // A slow channel reports one clock late, as a busy scan would
    always @(posedge clk) begin
        stage <= cmd;
        chan <= slow ? stage : cmd;
    end
endmodule
`default_nettype wire

// *** ccc_top_tb_top.sv ***
// Self-checking bench for the cascade coordinator.
// Assumes the channel model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ccc_top_tb_top;
    logic clk, rst_n, wr, rd, slow, tick;
    logic [7:0] addr, mman, rsl, rms;
    logic [31:0] wdata, rdata;
    logic [239:0] cmd, chan;
    logic [63:0] corr, ext;
    int failures, samples_checked;

    ccc_chan_model ccc_chan_model_i (.clk(clk), .slow(slow), .cmd(cmd),
        .chan(chan));
    ccc_top #(.CH(8), .CYCLE_CLKS(16)) ccc_top_i (
        .CLK(clk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .PID_Y(chan[63:0]),
        .PROC_PCT(chan[127:64]), .OPER_MANUAL(chan[191:128]),
        .AUTO_MODE(chan[199:192]), .SECOND_SETPOINT(chan[207:200]),
        .OUTPUTS_OFF(chan[215:208]), .SENSOR_BREAK(chan[223:216]),
        .TUNING(chan[231:224]), .EXT_TO_INT(chan[239:232]),
        .CORRECT_OUT(corr), .EXT_SETPOINT(ext), .MASTER_MANUAL(mman),
        .ROLE_SLAVE(rsl), .ROLE_MASTER(rms), .CYCLE_TICK(tick));

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(what, e, rdata);
    endtask
    // Selector 0 makes a master, 1..8 a slave of channel sel - 1
    task automatic cfg(input int ch, input int sel, input int brk);
        wr_reg(8'(ch * 4), sel == 0 ? 32'h02 : 32'h100);
        wr_reg(8'(32 + ch * 4), 32'(brk * 16 + sel));
    endtask
    task automatic put(input int f, input int ch, input logic [7:0] v);
        @(posedge clk);
        cmd[f*64 + ch*8 +: 8] <= v;
    endtask
    // Toggle one status bit; from the idle state this is an event
    task automatic tog(input int k, input int ch);
        @(posedge clk);
        cmd[192 + k*8 + ch] <= ~cmd[192 + k*8 + ch];
    endtask
    // Bounded wait for n ticks, then let the exchange land
    task automatic settle(input int n);
        int c;
        c = 0;
        // Let the slow channel pipeline flush before counting ticks
        repeat (3) @(posedge clk);
        repeat (n) begin
            do begin
                @(posedge clk);
                #1 c++;
            end while (tick !== 1'b1 && c < 400);
        end
        if (c >= 400) begin
            failures++;
            print_verdict();
        end
        repeat (3) @(posedge clk);
        #1;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        logic [7:0] brk_exp [3];
        brk_exp = '{8'h32, 8'h64, 8'h00};
        failures = 0;
        samples_checked = 0;
        {rst_n, wr, rd, slow, addr, wdata} = '0;
        cmd = '0;
        cmd[199:192] = 8'hFF;
        for (int i = 0; i < 8; i++) begin
            cmd[i*8 +: 8] = 8'(16 + i);
            cmd[64 + i*8 +: 8] = 8'(64 + i);
            cmd[128 + i*8 +: 8] = 8'(16 + i);
        end
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(8'h40, 32'h0, "roles after reset");
        cfg(0, 0, 0);
        for (int s = 1; s < 8; s++) cfg(s, 1, 0);
        rd_chk(8'h00, 32'h02, "main config");
        rd_chk(8'h24, 32'h01, "routing");
        rd_chk(8'h80, 32'h0, "unmapped");
        settle(2);
        rd_chk(8'h40, 32'hFE01, "roles one by seven");
        check("master role", 8'h01, rms);
        check("correcting out", 8'h10, corr[7:0]);
        for (int s = 1; s < 8; s++) check("ext", 8'h10, ext[s*8 +: 8]);
        $display("test one master seven slaves done");
        tog(0, 0);
        tog(1, 0);
        settle(3);
        check("manual after mode change", 8'h00, mman);
        check("slave ext", 8'h10, ext[15:8]);
        tog(0, 0);
        tog(1, 0);
        tog(2, 0);
        settle(3);
        check("off output", 8'h00, corr[7:0]);
        check("off slave ext", 8'h00, ext[15:8]);
        tog(2, 0);
        tog(3, 0);
        for (int b = 0; b < 3; b++) begin
            cfg(0, 0, b);
            settle(3);
            check("break output", brk_exp[b], corr[7:0]);
            check("break slave ext", brk_exp[b], ext[23:16]);
        end
        tog(3, 0);
        tog(4, 0);
        put(0, 0, 8'h5C);
        settle(3);
        check("tuning slave ext", 8'h5C, ext[55:48]);
        tog(4, 0);
        put(0, 0, 8'h10);
        $display("test master switch-over done");
        // Slave events, with the channels answering slowly
        slow <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            tog(k, 3);
            put(2, 0, 8'h5A);
            settle(3);
            check("cascade manual", 8'h01, mman);
            check("tracking", 8'h43, corr[7:0]);
            check("tracking ext", 8'h43, ext[15:8]);
            tog(k, 3);
            settle(3);
            check("closed manual", 8'h00, mman);
            check("closed output", 8'h10, corr[7:0]);
        end
        slow <= 1'b0;
        $display("test slave events done");
        tog(1, 2);
        settle(3);
        tog(1, 5);
        put(1, 5, 8'h61);
        settle(3);
        check("last opened wins", 8'h61, corr[7:0]);
        put(1, 2, 8'h22);
        settle(3);
        check("last written wins", 8'h22, corr[7:0]);
        tog(1, 2);
        tog(1, 5);
        settle(3);
        $display("test several open slaves done");
        for (int m = 0; m < 4; m++) cfg(m, 0, 0);
        for (int s = 4; s < 8; s++) cfg(s, s - 3, 0);
        settle(2);
        rd_chk(8'h40, 32'hF00F, "roles four by four");
        check("slave roles", 8'hF0, rsl);
        for (int s = 4; s < 8; s++) check("ext", 12 + s, ext[s*8 +: 8]);
        $display("test four masters four slaves done");
        print_verdict();
    end
endmodule
`default_nettype wire
